// ### rtl/sfw_status_wp.sv
`timescale 1ns/10ps
`include "sfw_regs.svh"

module sfw_status_wp #(
  parameter int unsigned TW_CYCLES =
    (`SFW_STATUS_WRITE_TIME_NS + `SFW_REF_CLK_PERIOD_NS - 1) /
    `SFW_REF_CLK_PERIOD_NS
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             RESETN_I,
  input  wire logic             SCLK_I,
  input  wire logic             CS_N_I,
  input  wire logic             SI_I,
  input  wire logic             WP_N_I,
  input  wire logic             PE_REQ_I,
  input  wire logic             PE_AREA_HIT_I,
  output logic                  PE_GRANT_O,
  output logic                  PE_REFUSE_O,
  output sfw_pkg::sfw_byte_t    STATUS_O,
  output sfw_pkg::sfw_byte_t    CONFIG_O,
  output logic                  BUSY_O,
  output logic                  HW_LOCK_MODE_O,
  output logic                  SW_LOCK_MODE_O,
  output logic                  PROTECT_FROM_BOTTOM_O,
  output logic                  QUAD_IO_EN_O,
  output logic [3:0]            QUAD_DUMMY_CYCLES_O
);
  import sfw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shifts the frame in on the serial clock.

  logic        fresh_reg;
  logic [5:0]  bit_cnt_reg;
  logic [23:0] shift_reg;

  // A raised chip select marks the next serial edge as the first of a frame.
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // Count and data are not cleared by chip select, so they stay still for
  // the reference domain to pick up once the serial clock has stopped.
  always_ff @(posedge SCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 24'h00_0000;
    end else begin
      shift_reg <= {shift_reg[22:0], SI_I};
      if (fresh_reg) begin
        bit_cnt_reg <= 6'h01;
      end else if (bit_cnt_reg != `SFW_FRAME_SAT) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers in the reference domain.

  logic [2:0] cs_sync_reg;
  logic [2:0] wp_sync_reg;
  logic       cs_level_reg;
  logic       wp_level_reg;
  logic       frame_end;

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cs_sync_reg <= 3'h7;
      wp_sync_reg <= 3'h7;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], CS_N_I};
      wp_sync_reg <= {wp_sync_reg[1:0], WP_N_I};
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cs_level_reg <= 1'b1;
      wp_level_reg <= 1'b1;
    end else begin
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_level_reg <= cs_sync_reg[2];
      end
      if (wp_sync_reg[1] == wp_sync_reg[2]) begin
        wp_level_reg <= wp_sync_reg[2];
      end
    end
  end

  assign frame_end = cs_sync_reg[1] & cs_sync_reg[2] & ~cs_level_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode, done once on the synchronised rise of chip select.

  logic       len_one;
  logic       len_two;
  logic       len_three;
  logic       on_boundary;
  sfw_byte_t  opcode;
  sfw_byte_t  status_data;
  sfw_byte_t  config_data;
  sfw_state_e state_reg;
  sfw_byte_t  status_reg;
  sfw_byte_t  config_reg;
  logic       hw_lock_reg;
  logic       status_write_ok;
  logic       latch_set_ok;
  logic       latch_clr_ok;

  assign len_one     = bit_cnt_reg == `SFW_FRAME_ONE_BYTE;
  assign len_two     = bit_cnt_reg == `SFW_FRAME_TWO_BYTES;
  assign len_three   = bit_cnt_reg == `SFW_FRAME_THREE_BYTES;
  assign on_boundary = len_one | len_two | len_three;

  always_comb begin
    opcode      = shift_reg[23:16];
    status_data = shift_reg[15:8];
    config_data = shift_reg[7:0];
    if (len_one) begin
      opcode = shift_reg[7:0];
    end else if (len_two) begin
      opcode      = shift_reg[15:8];
      status_data = shift_reg[7:0];
    end
  end

  assign status_write_ok = frame_end && (state_reg == SFW_IDLE) &&
                           opcode == `SFW_CMD_STATUS_WRITE &&
                           (len_two || len_three) &&
                           status_reg[`SFW_ST_LATCH_BIT] &&
                           !hw_lock_reg;
  assign latch_set_ok = frame_end && (state_reg == SFW_IDLE) && len_one &&
                        opcode == `SFW_CMD_WRITE_LATCH_SET;
  assign latch_clr_ok = frame_end && (state_reg == SFW_IDLE) && len_one &&
                        opcode == `SFW_CMD_WRITE_LATCH_CLR;

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed status write cycle.

  logic [31:0] tw_cnt_reg;
  sfw_byte_t   pend_status_reg;
  sfw_byte_t   pend_config_reg;
  logic        pend_has_cfg_reg;
  logic        write_done;

  assign write_done = (state_reg == SFW_WRITING) &&
                      (tw_cnt_reg == TW_CYCLES - 1);

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg  <= SFW_IDLE;
      tw_cnt_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        SFW_IDLE: begin
          tw_cnt_reg <= 32'h0000_0000;
          if (status_write_ok) begin
            state_reg <= SFW_WRITING;
          end
        end
        SFW_WRITING: begin
          tw_cnt_reg <= tw_cnt_reg + 32'h0000_0001;
          if (write_done) begin
            state_reg <= SFW_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pend_status_reg  <= `SFW_STATUS_RST;
      pend_config_reg  <= `SFW_CONFIG_RST;
      pend_has_cfg_reg <= 1'b0;
    end else if (status_write_ok) begin
      pend_status_reg  <= status_data;
      pend_config_reg  <= config_data;
      pend_has_cfg_reg <= len_three;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and configuration bytes.

  // Only lock, quad and level bits take written data; latch and busy stay
  // under hardware control.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status_reg <= `SFW_STATUS_RST;
    end else begin
      if (write_done) begin
        status_reg[7:2] <= pend_status_reg[7:2];
        status_reg[`SFW_ST_LATCH_BIT] <= 1'b0;
      end else if (latch_set_ok) begin
        status_reg[`SFW_ST_LATCH_BIT] <= 1'b1;
      end else if (latch_clr_ok) begin
        status_reg[`SFW_ST_LATCH_BIT] <= 1'b0;
      end
      status_reg[`SFW_ST_BUSY_BIT] <=
        status_write_ok || (state_reg == SFW_WRITING && !write_done);
    end
  end

  // The top/bottom select can be set by a write but cleared only by reset, since it models a
  // one-time programmable cell; reserved bits always read as zero.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      config_reg <= `SFW_CONFIG_RST;
    end else if (write_done && pend_has_cfg_reg) begin
      config_reg[`SFW_CFG_DUMMY_BIT] <= pend_config_reg[`SFW_CFG_DUMMY_BIT];
      config_reg[`SFW_CFG_TOPBOT_BIT] <= config_reg[`SFW_CFG_TOPBOT_BIT] |
        pend_config_reg[`SFW_CFG_TOPBOT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection mode and derived outputs.

  logic [3:0] dummy_reg;

  // Either order of lock bit and pin gives the same level product; quad
  // operation takes the pin over, so it cannot lock anything.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hw_lock_reg <= 1'b0;
    end else begin
      hw_lock_reg <= status_reg[`SFW_ST_LOCK_BIT] && !wp_level_reg &&
                     !status_reg[`SFW_ST_QUAD_BIT];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dummy_reg <= `SFW_DUMMY_SHORT;
    end else begin
      dummy_reg <= config_reg[`SFW_CFG_DUMMY_BIT] ?
                   `SFW_DUMMY_LONG : `SFW_DUMMY_SHORT;
    end
  end

  assign PE_REFUSE_O = PE_REQ_I && PE_AREA_HIT_I && hw_lock_reg;
  assign PE_GRANT_O  = PE_REQ_I && !PE_REFUSE_O;

  assign STATUS_O              = status_reg;
  assign CONFIG_O              = config_reg;
  assign BUSY_O                = status_reg[`SFW_ST_BUSY_BIT];
  assign HW_LOCK_MODE_O        = hw_lock_reg;
  assign SW_LOCK_MODE_O        = !hw_lock_reg;
  assign PROTECT_FROM_BOTTOM_O = config_reg[`SFW_CFG_TOPBOT_BIT];
  assign QUAD_IO_EN_O          = status_reg[`SFW_ST_QUAD_BIT];
  assign QUAD_DUMMY_CYCLES_O   = dummy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking ast_cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  AST_BUSY_ON_ACCEPT: assert property (
    status_write_ok |=> BUSY_O && state_reg == SFW_WRITING)
    else $error("busy not raised after accepted status write");

  AST_BUSY_HOLDS: assert property (
    $rose(BUSY_O) |-> BUSY_O [*8])
    else $error("busy dropped early in the write cycle");

  AST_DONE_CLEARS: assert property (
    $fell(BUSY_O) |-> !status_reg[`SFW_ST_LATCH_BIT] &&
                      $past(state_reg) == SFW_WRITING)
    else $error("write cycle end left latch set");

  AST_HW_REFUSE: assert property (
    frame_end && hw_lock_reg && state_reg == SFW_IDLE |=> !BUSY_O)
    else $error("status write ran in hardware lock mode");

  AST_OFF_BOUNDARY: assert property (
    frame_end && !on_boundary && state_reg == SFW_IDLE
      |=> !BUSY_O ##1 $stable(status_reg))
    else $error("frame off byte boundary was executed");

  AST_HW_ENTER: assert property (
    (status_reg[7] && !wp_level_reg && !status_reg[6]) [*2] |-> hw_lock_reg)
    else $error("hardware lock mode not entered");

  AST_QUAD_NO_LOCK: assert property (
    status_reg[`SFW_ST_QUAD_BIT] ##1 status_reg[`SFW_ST_QUAD_BIT]
      |-> !hw_lock_reg)
    else $error("hardware lock active with quad operation");

  AST_TB_STICKY: assert property (
    config_reg[`SFW_CFG_TOPBOT_BIT] |=> config_reg[`SFW_CFG_TOPBOT_BIT])
    else $error("top/bottom select was cleared");

  AST_LATCH_SET: assert property (
    latch_set_ok |=> status_reg[`SFW_ST_LATCH_BIT])
    else $error("latch-set frame did not set latch");

  AST_DUMMY: assert property (
    config_reg[`SFW_CFG_DUMMY_BIT] ##1 config_reg[`SFW_CFG_DUMMY_BIT]
      |-> QUAD_DUMMY_CYCLES_O == `SFW_DUMMY_LONG)
    else $error("dummy count not eight");

  AST_PE_REFUSE: assert property (
    PE_REQ_I && PE_AREA_HIT_I && hw_lock_reg |-> PE_REFUSE_O && !PE_GRANT_O)
    else $error("program/erase granted in locked area");

  COV_STATUS_WRITE: cover property (status_write_ok ##[1:1000] $fell(BUSY_O));
  COV_CFG_WRITE: cover property (status_write_ok && len_three);
  COV_HW_REFUSE: cover property (frame_end && hw_lock_reg &&
                                 opcode == `SFW_CMD_STATUS_WRITE);
  COV_LATCH_SET: cover property (latch_set_ok);

endmodule

// ### rtl/sfw_regs.svh
`ifndef SFW_REGS_SVH
`define SFW_REGS_SVH

// Instruction codes seen on the serial input.
`define SFW_CMD_STATUS_WRITE   8'h01
`define SFW_CMD_WRITE_LATCH_SET 8'h06
`define SFW_CMD_WRITE_LATCH_CLR 8'h04

// Status byte field positions.
`define SFW_ST_LOCK_BIT        7
`define SFW_ST_QUAD_BIT        6
`define SFW_ST_LEVEL_HI        5
`define SFW_ST_LEVEL_LO        2
`define SFW_ST_LATCH_BIT       1
`define SFW_ST_BUSY_BIT        0

// Configuration byte field positions.
`define SFW_CFG_DUMMY_BIT      7
`define SFW_CFG_TOPBOT_BIT     3

// Reset values (quad I/O enabled as shipped, everything else clear).
`define SFW_STATUS_RST         8'h40
`define SFW_CONFIG_RST         8'h00

// Dummy cycle counts for quad I/O fast read.
`define SFW_DUMMY_LONG         4'h8
`define SFW_DUMMY_SHORT        4'h6

// Frame lengths in bits that end on a byte boundary, and the bit count's saturation value.
`define SFW_FRAME_ONE_BYTE     6'h08
`define SFW_FRAME_TWO_BYTES    6'h10
`define SFW_FRAME_THREE_BYTES  6'h18
`define SFW_FRAME_SAT          6'h3F

// Timing.
`define SFW_REF_CLK_PERIOD_NS  50
`define SFW_STATUS_WRITE_TIME_NS 10000000

`endif

// ### rtl/sfw_pkg.sv
package sfw_pkg;

  typedef logic [7:0] sfw_byte_t;

  typedef enum logic [0:0] {
    SFW_IDLE    = 1'b0,
    SFW_WRITING = 1'b1
  } sfw_state_e;

endpackage

// ### tb/sfw_host.sv
`timescale 1ns/10ps
module sfw_host (
  input  wire logic ref_clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shifts the low n bits of v out MSB first at a 32 ns link period.
  // The link clock stands low outside frames, as a real host leaves it.
  task automatic frame(input logic [23:0] v, input int n);
    @(posedge ref_clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = v[i];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    // The line has no pull, so a released line must not echo the last bit.
    si_o = ~si_o;
    // Select stays high for six reference cycles, above the minimum.
    #300;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sfw_pkg::*;
  localparam int TW = 20;
  logic       clk;
  logic       rst_n;
  logic       wp_n;
  logic       pe_req;
  logic       pe_hit;
  logic       sclk;
  logic       cs_n;
  logic       si;
  logic       grant;
  logic       refuse;
  logic       busy;
  logic       hw;
  logic       sw;
  logic       bot;
  logic       quad;
  logic [3:0] dummy;
  sfw_byte_t  status;
  sfw_byte_t  cfg;
  int         fails = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         k;

  sfw_host host (.ref_clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  sfw_status_wp #(.TW_CYCLES(TW)) dut (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SI_I(si), .WP_N_I(wp_n), .PE_REQ_I(pe_req), .PE_AREA_HIT_I(pe_hit),
    .PE_GRANT_O(grant), .PE_REFUSE_O(refuse), .STATUS_O(status),
    .CONFIG_O(cfg), .BUSY_O(busy), .HW_LOCK_MODE_O(hw),
    .SW_LOCK_MODE_O(sw), .PROTECT_FROM_BOTTOM_O(bot),
    .QUAD_IO_EN_O(quad), .QUAD_DUMMY_CYCLES_O(dummy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Polls busy with a bound, as a host must before the next write.
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    // A busy flag that never drops counts as a mismatch here.
    chk({7'h0, busy}, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    pe_req = 1'b0;
    pe_hit = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(4);
    chk(status, 8'h40);
    chk(cfg, 8'h00);
    chk({4'h0, dummy}, 8'h06);
    chk({7'h0, hw}, 8'h00);
    host.frame(24'h0001BC, 16);
    tick(2);
    chk(status, 8'h40);
    host.frame(24'h000006, 8);
    tick(2);
    chk(status, 8'h42);
    host.frame(24'h000004, 8);
    tick(2);
    chk(status, 8'h40);
    host.frame(24'h000006, 8);
    tick(2);
    host.frame(24'h0001BF, 16);
    chk({6'h0, busy, status[0]}, 8'h03);
    wait_idle(k);
    chk({7'h0, (k >= TW - 6 && k <= TW)}, 8'h01);
    chk(status, 8'hBC);
    wp_n = 1'b0;
    tick(6);
    chk({6'h0, hw, sw}, 8'h02);
    pe_req = 1'b1;
    pe_hit = 1'b1;
    #1 chk({6'h0, refuse, grant}, 8'h02);
    tick(1);
    pe_hit = 1'b0;
    #1 chk({6'h0, refuse, grant}, 8'h01);
    tick(1);
    pe_req = 1'b0;
    host.frame(24'h000006, 8);
    tick(2);
    chk(status, 8'hBE);
    host.frame(24'h000100, 16);
    tick(2);
    chk({busy, status[6:0]}, 8'h3E);
    chk(status, 8'hBE);
    wp_n = 1'b1;
    tick(6);
    chk({6'h0, hw, sw}, 8'h01);
    // Fifteen bits: the frame ends off a byte boundary.
    host.frame(24'h000080, 15);
    tick(2);
    chk(status, 8'hBE);
    host.frame(24'h01C088, 24);
    wait_idle(k);
    tick(2);
    chk(status, 8'hC0);
    chk(cfg, 8'h88);
    chk({6'h0, bot, quad}, 8'h03);
    chk({4'h0, dummy}, 8'h08);
    wp_n = 1'b0;
    tick(6);
    chk({7'h0, hw}, 8'h00);
    chk({7'h0, sw}, 8'h01);
    host.frame(24'h000006, 8);
    host.frame(24'h018000, 24);
    wait_idle(k);
    tick(2);
    chk(status, 8'h80);
    chk(cfg, 8'h08);
    chk({3'h0, hw, dummy}, 8'h16);
    // A reset in mid-run must bring back the shipped state.
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    chk(status, 8'h40);
    chk(cfg, 8'h00);
    chk({7'h0, hw}, 8'h00);
    tally_and_finish();
  end
endmodule
